// file: dst_map.svh
`ifndef DST_MAP_SVH
`define DST_MAP_SVH

// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define DST_ROW_TIMING_OFS     12'h000
`define DST_COL_TIMING_OFS     12'h004
`define DST_ACK_TIMING_OFS     12'h008
`define DST_STATUS_OFS         12'h00C
`define DST_ROW_TIMING_RST     8'h00
`define DST_COL_TIMING_RST     8'h00
`define DST_ACK_TIMING_RST     8'h00

// ****************************************************************
// Row strobe timing fields
// ****************************************************************
`define DST_ROW_HOLD_LSB       1
`define DST_ROW_HOLD_MSB       2
`define DST_ROW_ACTIVE_LSB     3
`define DST_ROW_ACTIVE_MSB     5
`define DST_ROW_PRE_TOP_BIT    0
`define DST_ROW_PRE_LSB        6
`define DST_ROW_PRE_MSB        7

// ****************************************************************
// Column strobe timing fields
// ****************************************************************
`define DST_REL_DELAY_BIT      0
`define DST_COL_SETUP_BIT      1
`define DST_LATER_WIDTH_LSB    2
`define DST_LATER_WIDTH_MSB    3
`define DST_FIRST_WIDTH_LSB    4
`define DST_FIRST_WIDTH_MSB    5
`define DST_COL_PRE_LSB        6
`define DST_COL_PRE_MSB        7

// ****************************************************************
// Acknowledge delay fields, timer bank and check helper count
// ****************************************************************
`define DST_ACK_LATER_LSB      2
`define DST_ACK_LATER_MSB      4
`define DST_ACK_FIRST_LSB      5
`define DST_ACK_FIRST_MSB      7
`define DST_TIMER_COUNT        5
`define DST_OBS_COUNT          6

`endif

// file: dst_pkg.sv
package dst_pkg;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ROW_HOLD = 3'b001,
      ST_COL_SETUP = 3'b010,
      ST_CAS_ACT  = 3'b011,
      ST_ACK      = 3'b100,
      ST_CAS_NEG  = 3'b101,
      ST_RAS_END  = 3'b110
   } dst_state_type;

   typedef enum logic [2:0] {
      TMR_STEP  = 3'b000,
      TMR_RAS_W = 3'b001,
      TMR_RAS_P = 3'b010,
      TMR_CAS_W = 3'b011,
      TMR_CAS_P = 3'b100
   } dst_tmr_type;

endpackage

// file: dst_timer.sv
`timescale 1ns/1ns

module dst_timer #(
   parameter int CW = 4
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          resetn,
   // Load and status
   input  wire logic          load,
   input  wire logic [CW-1:0] count,
   output logic              done
);

   logic [CW-1:0] cnt;

   // Done rises in the cycle before the count expires, so a state change
   // taken on that edge lands exactly count edges after the load.
   assign done = (cnt <= CW'(1));

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= count;
      end else if (cnt != '0) begin
         cnt <= cnt - CW'(1);
      end
   end

endmodule

// file: dst_ctrl.sv
// Function
// [R1] Row address stays on the muxed address for the programmed hold after row strobe.
// [R2] Row strobe stays asserted for at least the programmed active width.
// [R3] Row strobe stays high for the programmed precharge before reassertion.
// [R4] Column strobe releases one or three phases after sync ready negates.
// [R5] Column address leads column strobe by one or two half cycles.
// [R6] Later words of a multiword transfer use the later-word column width.
// [R7] First word holds column strobe for two to five half cycles.
// [R8] Column strobe stays high for the programmed column precharge.
// [R9] Ready and acknowledge follow column strobe after the programmed delay.
// [R10] Software must not write undefined field codes; they decode as longest.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "dst_map.svh"

module dst_ctrl #(
   parameter int AW = 10
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          resetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic              [31:0] prdata,
   output logic              pready,
   output logic              pslverr,
   // Access request
   input  wire logic          acc_valid,
   input  wire logic [AW-1:0] acc_row_addr,
   input  wire logic [AW-1:0] acc_col_addr,
   input  wire logic [1:0]    acc_words,
   output logic              acc_accept,
   output logic              acc_done,
   // DRAM strobes and address
   output logic              row_strobe_out_n,
   output logic              column_strobe_out_n,
   output logic     [AW-1:0] muxed_address_out,
   // Bus acknowledge
   output logic              sync_ready_n,
   output logic              transfer_acknowledge_n
);
   import dst_pkg::*;

   // ****************************************************************
   // Registers and decoded fields
   // ****************************************************************
   logic [7:0]    row_strobe_timing;
   logic [7:0]    column_strobe_timing;
   logic [7:0]    ack_delay_register;
   dst_state_type state;
   dst_state_type next_state;
   logic [AW-1:0] col_addr;
   logic [1:0]    words_left;
   logic          first_word;
   logic [3:0]    tmr_val [`DST_TIMER_COUNT];
   logic [`DST_TIMER_COUNT-1:0] tmr_load;
   logic [`DST_TIMER_COUNT-1:0] tmr_done;

   wire [1:0] row_hold_field = row_strobe_timing[`DST_ROW_HOLD_MSB:`DST_ROW_HOLD_LSB];
   wire [2:0] row_active_width_field =
      row_strobe_timing[`DST_ROW_ACTIVE_MSB:`DST_ROW_ACTIVE_LSB];
   wire [2:0] row_precharge_field = {row_strobe_timing[`DST_ROW_PRE_TOP_BIT],
                                     row_strobe_timing[`DST_ROW_PRE_MSB:`DST_ROW_PRE_LSB]};
   wire       strobe_release_delay_bit = column_strobe_timing[`DST_REL_DELAY_BIT];
   wire       column_setup_bit = column_strobe_timing[`DST_COL_SETUP_BIT];
   wire [1:0] later_word_width_field =
      column_strobe_timing[`DST_LATER_WIDTH_MSB:`DST_LATER_WIDTH_LSB];
   wire [1:0] first_word_width_field =
      column_strobe_timing[`DST_FIRST_WIDTH_MSB:`DST_FIRST_WIDTH_LSB];
   wire [1:0] column_precharge_field =
      column_strobe_timing[`DST_COL_PRE_MSB:`DST_COL_PRE_LSB];
   wire [2:0] ack_first_field = ack_delay_register[`DST_ACK_FIRST_MSB:`DST_ACK_FIRST_LSB];
   wire [2:0] ack_later_field = ack_delay_register[`DST_ACK_LATER_MSB:`DST_ACK_LATER_LSB];

   // Half-cycle counts; one half cycle is one mclk period. Undefined codes
   // are clamped to the longest legal value so a bad write stays safe.
   wire [3:0] row_hold_n = (row_hold_field == 2'b11) ? 4'h3 :           // see [R10]
                           {2'b00, row_hold_field} + 4'h1;              // see [R1]
   wire [3:0] row_active_n = (row_active_width_field == 3'b111) ? 4'h7 :  // see [R10]
                             {1'b0, row_active_width_field} + 4'h1;     // see [R2]
   wire [3:0] row_pre_n = {1'b0, row_precharge_field} + 4'h1;           // see [R3]
   wire [3:0] release_n = strobe_release_delay_bit ? 4'h3 : 4'h1;       // see [R4]
   wire [3:0] col_setup_n = column_setup_bit ? 4'h2 : 4'h1;             // see [R5]
   wire [3:0] later_width_n = {2'b00, later_word_width_field} + 4'h1;   // see [R6]
   wire [3:0] first_width_n = {2'b00, first_word_width_field} + 4'h2;   // see [R7]
   wire [3:0] col_pre_n = (column_precharge_field == 2'b11) ? 4'h3 :    // see [R10]
                          {2'b00, column_precharge_field} + 4'h1;       // see [R8]
   wire [3:0] ack_first_n = {1'b0, ack_first_field} + 4'h1;
   wire [3:0] ack_later_n = {1'b0, ack_later_field} + 4'h1;
   wire [3:0] ack_cur_n = first_word ? ack_first_n : ack_later_n;       // see [R9]
   wire [3:0] width_cur_n = first_word ? first_width_n : later_width_n;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   wire        sel_row = (paddr == `DST_ROW_TIMING_OFS);
   wire        sel_col = (paddr == `DST_COL_TIMING_OFS);
   wire        sel_ack = (paddr == `DST_ACK_TIMING_OFS);
   wire        sel_sts = (paddr == `DST_STATUS_OFS);
   wire        sel_any = sel_row | sel_col | sel_ack | sel_sts;
   wire        apb_wr = psel & penable & pwrite;
   wire        busy = (state != ST_IDLE);
   wire [7:0]  status = {busy, state, first_word, 1'b0, words_left};
   wire [31:0] rd_mux = sel_row ? {24'h00_0000, row_strobe_timing} :
                        sel_col ? {24'h00_0000, column_strobe_timing} :
                        sel_ack ? {24'h00_0000, ack_delay_register} :
                        sel_sts ? {24'h00_0000, status} : 32'h0000_0000;

   // Zero wait states; an unmapped address ends with an error response.
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~sel_any;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         row_strobe_timing <= `DST_ROW_TIMING_RST;
         column_strobe_timing <= `DST_COL_TIMING_RST;
         ack_delay_register <= `DST_ACK_TIMING_RST;
      end else if (apb_wr) begin
         if (sel_row) row_strobe_timing <= pwdata[7:0];
         if (sel_col) column_strobe_timing <= pwdata[7:0];
         if (sel_ack) ack_delay_register <= pwdata[7:0];
      end
   end

   // Read data is captured in the setup phase so it comes from a flop.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // ****************************************************************
   // Strobe timers
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < `DST_TIMER_COUNT; g = g + 1) begin : gen_tmr
         dst_timer #(.CW(4)) u_tmr (
            .mclk   (mclk),
            .resetn (resetn),
            .load   (tmr_load[g]),
            .count  (tmr_val[g]),
            .done   (tmr_done[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   wire advance = (next_state != state);
   wire addr_load = advance && (next_state == ST_COL_SETUP);

   always_comb begin
      next_state = state;
      tmr_load = '0;
      tmr_val = '{default: 4'h0};
      case (state)
         ST_IDLE: begin
            if (acc_valid && tmr_done[TMR_RAS_P]) begin                // see [R3]
               next_state = ST_ROW_HOLD;
               tmr_load[TMR_STEP] = 1'b1;
               tmr_val[TMR_STEP] = row_hold_n;                          // see [R1]
               tmr_load[TMR_RAS_W] = 1'b1;
               tmr_val[TMR_RAS_W] = row_active_n;                       // see [R2]
            end
         end
         ST_ROW_HOLD: begin
            if (tmr_done[TMR_STEP]) begin                               // see [R1]
               next_state = ST_COL_SETUP;
               tmr_load[TMR_STEP] = 1'b1;
               tmr_val[TMR_STEP] = col_setup_n;                         // see [R5]
            end
         end
         ST_COL_SETUP: begin
            if (tmr_done[TMR_STEP] && tmr_done[TMR_CAS_P]) begin        // see [R8]
               next_state = ST_CAS_ACT;
               tmr_load[TMR_STEP] = 1'b1;
               tmr_val[TMR_STEP] = ack_cur_n;                           // see [R9]
               tmr_load[TMR_CAS_W] = 1'b1;
               tmr_val[TMR_CAS_W] = width_cur_n;                        // see [R6] [R7]
            end
         end
         ST_CAS_ACT: begin
            if (tmr_done[TMR_STEP]) begin
               next_state = ST_ACK;
            end
         end
         ST_ACK: begin
            next_state = ST_CAS_NEG;
            tmr_load[TMR_STEP] = 1'b1;
            tmr_val[TMR_STEP] = release_n;                              // see [R4]
         end
         ST_CAS_NEG: begin
            if (tmr_done[TMR_STEP] && tmr_done[TMR_CAS_W]) begin        // see [R4]
               tmr_load[TMR_CAS_P] = 1'b1;
               tmr_val[TMR_CAS_P] = col_pre_n;                          // see [R8]
               if (words_left != 2'b00) begin
                  next_state = ST_COL_SETUP;
                  tmr_load[TMR_STEP] = 1'b1;
                  tmr_val[TMR_STEP] = col_setup_n;                      // see [R5]
               end else begin
                  next_state = ST_RAS_END;
               end
            end
         end
         ST_RAS_END: begin
            if (tmr_done[TMR_RAS_W]) begin                              // see [R2]
               next_state = ST_IDLE;
               tmr_load[TMR_RAS_P] = 1'b1;
               tmr_val[TMR_RAS_P] = row_pre_n;                          // see [R3]
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         row_strobe_out_n <= 1'b1;
         column_strobe_out_n <= 1'b1;
         muxed_address_out <= '0;
         col_addr <= '0;
         words_left <= 2'b00;
         first_word <= 1'b0;
         sync_ready_n <= 1'b1;
         transfer_acknowledge_n <= 1'b1;
         acc_accept <= 1'b0;
         acc_done <= 1'b0;
      end else begin
         state <= next_state;
         acc_accept <= 1'b0;
         acc_done <= 1'b0;
         if (advance) begin
            case (state)
               ST_IDLE: begin
                  row_strobe_out_n <= 1'b0;
                  muxed_address_out <= acc_row_addr;
                  col_addr <= acc_col_addr;
                  words_left <= acc_words;
                  first_word <= 1'b1;
                  acc_accept <= 1'b1;
               end
               ST_ROW_HOLD: begin
                  muxed_address_out <= col_addr;                        // see [R1]
               end
               ST_COL_SETUP: begin
                  column_strobe_out_n <= 1'b0;                          // see [R5]
               end
               ST_CAS_ACT: begin
                  sync_ready_n <= 1'b0;                                 // see [R9]
                  transfer_acknowledge_n <= 1'b0;
               end
               ST_ACK: begin
                  sync_ready_n <= 1'b1;
                  transfer_acknowledge_n <= 1'b1;
               end
               ST_CAS_NEG: begin
                  column_strobe_out_n <= 1'b1;                          // see [R4]
                  first_word <= 1'b0;                                   // see [R6]
                  if (words_left != 2'b00) begin
                     words_left <= words_left - 2'b01;
                     muxed_address_out <= muxed_address_out + AW'(1);
                  end
               end
               ST_RAS_END: begin
                  row_strobe_out_n <= 1'b1;                             // see [R2]
                  acc_done <= 1'b1;
               end
               default: begin
                  row_strobe_out_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Each helper counts the cycles its level has held, saturating at 31.
   logic [4:0] obs_cnt [`DST_OBS_COUNT];
   wire [`DST_OBS_COUNT-1:0] obs_cond = {~addr_load, sync_ready_n, column_strobe_out_n,
                                         ~column_strobe_out_n, row_strobe_out_n,
                                         ~row_strobe_out_n};
   generate
      for (g = 0; g < `DST_OBS_COUNT; g = g + 1) begin : gen_obs
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               obs_cnt[g] <= 5'h00;
            end else if (!obs_cond[g]) begin
               obs_cnt[g] <= 5'h00;
            end else if (obs_cnt[g] != 5'h1F) begin
               obs_cnt[g] <= obs_cnt[g] + 5'h01;
            end
         end
      end
   endgenerate

   wire [4:0] ras_low = obs_cnt[0];
   wire [4:0] ras_high = obs_cnt[1];
   wire [4:0] cas_low = obs_cnt[2];
   wire [4:0] cas_high = obs_cnt[3];
   wire [4:0] rdy_high = obs_cnt[4];
   wire [4:0] addr_age = obs_cnt[5];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_ready_pulse;
      $fell(sync_ready_n) ##1 $rose(sync_ready_n);
   endsequence

   row_hold_a: assert property (                                        // see [R1]
      ($changed(muxed_address_out) && !row_strobe_out_n && $past(!row_strobe_out_n))
      |-> ras_low >= 5'(row_hold_n))
      else $error("row address left the bus before its hold time");
   row_width_a: assert property (                                       // see [R2]
      $rose(row_strobe_out_n) |-> $past(ras_low) >= 5'(row_active_n) - 5'd1)
      else $error("row strobe released before its minimum width");
   row_precharge_a: assert property (                                   // see [R3]
      $fell(row_strobe_out_n) |-> $past(ras_high) >= 5'(row_pre_n) - 5'd1)
      else $error("row strobe reasserted before precharge ended");
   cas_release_a: assert property (                                     // see [R4]
      s_ready_pulse |-> ##[0:8] $rose(column_strobe_out_n) ##0
      ($past(rdy_high) >= 5'(release_n) - 5'd1))
      else $error("column strobe release not tied to ready negation");
   col_setup_a: assert property (                                       // see [R5]
      $fell(column_strobe_out_n) |-> $past(addr_age) >= 5'(col_setup_n) - 5'd1)
      else $error("column strobe asserted before address set-up");
   later_width_a: assert property (                                     // see [R6]
      ($rose(column_strobe_out_n) && !$past(first_word))
      |-> $past(cas_low) >= 5'(later_width_n) - 5'd1)
      else $error("later word column strobe too short");
   first_width_a: assert property (                                     // see [R7]
      ($rose(column_strobe_out_n) && $past(first_word))
      |-> $past(cas_low) >= 5'(first_width_n) - 5'd1)
      else $error("first word column strobe too short");
   col_precharge_a: assert property (                                   // see [R8]
      $fell(column_strobe_out_n) |-> $past(cas_high) >= 5'(col_pre_n) - 5'd1)
      else $error("column strobe reasserted before precharge ended");
   ack_delay_a: assert property (                                       // see [R9]
      $fell(sync_ready_n) |-> !column_strobe_out_n &&
      ($past(cas_low) == 5'(ack_cur_n) - 5'd1))
      else $error("ready asserted at the wrong delay after column strobe");
   ack_pair_a: assert property (                                        // see [R9]
      $fell(transfer_acknowledge_n) |-> $fell(sync_ready_n) ##1 sync_ready_n)
      else $error("acknowledge and ready out of step");

endmodule

// file: dst_dram_model.sv
`timescale 1ns/1ns

module dst_dram_model #(
   parameter int AW = 10
) (
   // Clock
   input wire logic          mclk,
   // Strobes, address and ready
   input wire logic          row_strobe_out_n,
   input wire logic          column_strobe_out_n,
   input wire logic [AW-1:0] muxed_address_out,
   input wire logic          sync_ready_n
);
   // Only edge distances are kept, so sampling the pre-edge values is exact.
   logic [15:0]   cyc = '0, t_rf = '0, t_rr = '0, t_ac = '0, t_cf = '0, t_cr = '0, t_yr = '0;
   logic [7:0]    m_hold, m_setup, m_ackf, m_ackl, m_rel, m_cfw, m_clw, m_chi, m_rlo, m_rhi;
   logic [7:0]    m_words;
   logic [AW-1:0] m_row, m_col, p_addr;
   logic          p_row = 1'b1, p_col = 1'b1, p_rdy = 1'b1, held = 1'b1;

   always @(posedge mclk) begin
      cyc <= cyc + 16'd1;
      p_row <= row_strobe_out_n;
      p_col <= column_strobe_out_n;
      p_rdy <= sync_ready_n;
      p_addr <= muxed_address_out;
      if (muxed_address_out != p_addr) t_ac <= cyc;
      if (p_row && !row_strobe_out_n) begin
         t_rf <= cyc;
         m_rhi <= 8'(cyc - t_rr);
         m_row <= muxed_address_out;
         m_words <= '0;
         m_chi <= 8'hFF;
         m_clw <= 8'hFF;
         held <= 1'b0;
      end
      if (!p_row && !held && muxed_address_out != p_addr) begin
         m_hold <= 8'(cyc - t_rf);
         held <= 1'b1;
      end
      if (!p_row && row_strobe_out_n) begin
         m_rlo <= 8'(cyc - t_rf);
         t_rr <= cyc;
      end
      if (p_col && !column_strobe_out_n) begin
         t_cf <= cyc;
         m_col <= muxed_address_out;
         if (m_words == 0) m_setup <= 8'(cyc - t_ac);
         else if (8'(cyc - t_cr) < m_chi) m_chi <= 8'(cyc - t_cr);
      end
      if (p_rdy && !sync_ready_n) begin
         if (m_words == 0) m_ackf <= 8'(cyc - t_cf);
         else m_ackl <= 8'(cyc - t_cf);
      end
      if (!p_rdy && sync_ready_n) t_yr <= cyc;
      if (!p_col && column_strobe_out_n) begin
         t_cr <= cyc;
         m_words <= m_words + 8'd1;
         if (m_words == 0) begin
            m_cfw <= 8'(cyc - t_cf);
            m_rel <= 8'(cyc - t_yr);
         end else if (8'(cyc - t_cf) < m_clw) m_clw <= 8'(cyc - t_cf);
      end
   end
endmodule

// file: dram_strobe_timing_regs_bench.sv
`timescale 1ns/1ns
`include "dst_map.svh"

module dram_strobe_timing_regs_bench;
   localparam int AW = 10;
   logic          mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0, prdata;
   logic          pready, pslverr, acc_valid = 1'b0, acc_accept, acc_done, ack_bad = 1'b0;
   logic [AW-1:0] acc_row_addr = 10'h2A5, acc_col_addr = 10'h0F8, muxed_address_out;
   logic [1:0]    acc_words = '0;
   logic          row_strobe_out_n, column_strobe_out_n, sync_ready_n, transfer_acknowledge_n;
   int            n_errors = 0, checked = 0;

   always #25 mclk = ~mclk;

   dst_ctrl #(.AW(AW)) dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .acc_valid(acc_valid), .acc_row_addr(acc_row_addr),
      .acc_col_addr(acc_col_addr), .acc_words(acc_words), .acc_accept(acc_accept),
      .acc_done(acc_done), .row_strobe_out_n(row_strobe_out_n),
      .column_strobe_out_n(column_strobe_out_n), .muxed_address_out(muxed_address_out),
      .sync_ready_n(sync_ready_n), .transfer_acknowledge_n(transfer_acknowledge_n));

   dst_dram_model #(.AW(AW)) dram (.mclk(mclk), .row_strobe_out_n(row_strobe_out_n),
      .column_strobe_out_n(column_strobe_out_n), .muxed_address_out(muxed_address_out),
      .sync_ready_n(sync_ready_n));

   // ************************************************************
   // Reporting and comparison
   // ************************************************************
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic bad(input logic [31:0] got, input logic [31:0] exp);
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) bad(got, exp);
   endtask

   task automatic chk_ge(input logic [7:0] got, input logic [7:0] low);
      checked++;
      if (!(got >= low) || $isunknown(got)) bad({24'h0, got}, {24'h0, low});
   endtask

   task automatic hang(input int n);
      if (n >= 200) begin
         n_errors++;
         give_verdict;
      end
   endtask

   // ************************************************************
   // Bus and access drivers
   // ************************************************************
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      hang(n);
   endtask

   task automatic access(input logic [1:0] w);
      int n;
      acc_valid <= 1'b1;
      acc_words <= w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (acc_accept !== 1'b1 && n < 200);
      acc_valid <= 1'b0;
      hang(n);
      n = 0;
      do begin
         @(posedge mclk);
         if (transfer_acknowledge_n !== sync_ready_n) ack_bad = 1'b1;
         n++;
      end while (acc_done !== 1'b1 && n < 200);
      hang(n);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_regs;
      logic [31:0] d;
      logic        e;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(i * 4), '0, d, e);
         chk32(d, {24'h0, `DST_ROW_TIMING_RST});
         apb(1'b1, 12'(i * 4), 32'hFFFF_FFA5, d, e);
         apb(1'b0, 12'(i * 4), '0, d, e);
         chk32(d, 32'h0000_00A5);
      end
      apb(1'b1, 12'h010, 32'h0000_0033, d, e);
      chk32({31'h0, e}, 32'h0000_0001);
      apb(1'b0, 12'h010, '0, d, e);
      chk32({e, d[30:0]}, 32'h8000_0000);
      apb(1'b0, `DST_STATUS_OFS, '0, d, e);
      chk32({31'h0, e}, 32'h0000_0000);
      chk32(d, 32'h0000_0000);
      $display("test_regs done");
   endtask

   // Codes stay legal: undefined encodings are never programmed.
   task automatic run_cfg(input logic [7:0] r, input logic [7:0] c, input logic [7:0] a,
                          input logic [1:0] w);
      logic [31:0] d;
      logic        e;
      apb(1'b1, `DST_ROW_TIMING_OFS, {24'h0, r}, d, e);
      apb(1'b1, `DST_COL_TIMING_OFS, {24'h0, c}, d, e);
      apb(1'b1, `DST_ACK_TIMING_OFS, {24'h0, a}, d, e);
      access(w);
      access(w);
      // The model books the row release on the edge that shows acc_done, so let it settle.
      @(negedge mclk);
      chk32({24'h0, dram.m_hold}, {30'h0, r[2:1]} + 32'd1);
      chk_ge(dram.m_rlo, {5'h0, r[5:3]} + 8'd1);
      chk_ge(dram.m_rhi, {5'h0, r[0], r[7:6]} + 8'd1);
      chk_ge(dram.m_rel, c[0] ? 8'd3 : 8'd1);
      chk32({24'h0, dram.m_setup}, {31'h0, c[1]} + 32'd1);
      chk_ge(dram.m_cfw, {6'h0, c[5:4]} + 8'd2);
      chk32({24'h0, dram.m_ackf}, {29'h0, a[7:5]} + 32'd1);
      if (w != 2'd0) begin
         chk_ge(dram.m_clw, {6'h0, c[3:2]} + 8'd1);
         chk_ge(dram.m_chi, {6'h0, c[7:6]} + 8'd1);
         chk32({24'h0, dram.m_ackl}, {29'h0, a[4:2]} + 32'd1);
      end
      chk32({24'h0, dram.m_words}, {30'h0, w} + 32'd1);
      chk32({12'h0, dram.m_row, dram.m_col}, {12'h0, acc_row_addr, acc_col_addr + 10'(w)});
      chk32({31'h0, ack_bad}, 32'h0000_0000);
      $display("run_cfg %h %h %h done", r, c, a);
   endtask

   task automatic test_all_zero;
      run_cfg(8'h00, 8'h00, 8'h00, 2'd0);
   endtask

   task automatic test_long_burst;
      run_cfg(8'h75, 8'hBF, 8'h44, 2'd3);
   endtask

   task automatic test_long_precharge;
      run_cfg(8'hC3, 8'h50, 8'h1C, 2'd1);
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      test_regs;
      test_all_zero;
      test_long_burst;
      test_long_precharge;
      give_verdict;
   end
endmodule
